// ### acbs_boot.sv
`default_nettype none
// Overview of operation
// R1 - internal rom holds eight numbered configurations for boot
// R2 - board holds interface pins at 00, 01 or 10 for rom boot
// R3 - configuration index comes from three select pins sampled at reset
// R4 - interface pins 11 at reset boot from external spi eeprom
// R5 - internal eeprom variant selects one of eight stored configs
// R6 - test=1, select=000, interface=11 at reset enters direct write, with the internal eeprom variant only
// R7 - direct write maps eeprom for writing, blocks ordinary registers
// R8 - direct write mode ends at next reset rising edge; the code clears it as soon as reset falls
// R9 - miso driven continuously during direct write mode
// R10 - gpio0 can follow the boot done flag
// R11 - script writes 0x1f to source select, 0x04 to pin control
// R12 - boot controller starts when external reset returns high
// R13 - done flag set when boot completes; host waits for it
// R14 - soft reset bit resets logic but does not relaunch boot
// R15 - straps latched at reset release and held until next reset
module acbs_boot (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] host_if_select_pins,
    input wire logic test_pin,
    input wire logic [2:0] config_index_select_pins,
    input wire logic use_internal_eeprom,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output acbs_pkg::acbs_spi_out_t spi_out,
    output logic spi_miso_out,
    output logic spi_miso_oe_n,
    input wire logic spi_miso_in,
    output logic boot_config_done,
    output logic gpio0_out,
    output logic irq,
    output logic direct_write_mode
);
    import acbs_pkg::*;
    logic rst_meta, rst_sync_n;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end
    // two-flop sync of pins and spi input
    acbs_straps_t pins_m, pins_s;
    logic miso_m, miso_s;
    // no reset: pins settle while the core is held, ready at release
    always_ff @(posedge mclk) begin
        pins_m <= '{host_if_select_pins, test_pin,
                    config_index_select_pins};
        pins_s <= pins_m;
        miso_m <= spi_miso_in;
        miso_s <= miso_m;
    end
    acbs_state_t state_reg, state_next;
    acbs_straps_t straps_reg, straps_next;
    logic [3:0] idx_reg, idx_next;
    logic [3:0] bit_reg, bit_next;
    logic [1:0] phase_reg, phase_next;
    logic [23:0] shift_reg, shift_next;
    logic [15:0] rx_reg, rx_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] mask_reg, mask_next;
    logic [7:0] ist_reg, ist_next;
    logic [7:0] gss_reg, gss_next;
    logic [7:0] pc1_reg, pc1_next;
    logic [7:0] eea_reg, eea_next;
    logic [7:0] eed_reg, eed_next;
    logic [7:0] rdata_reg, rdata_next;
    logic done_reg, done_next;
    logic gpio_reg, gpio_next;
    logic irq_reg, irq_next;
    logic direct_reg, direct_next;
    logic started_reg, started_next;
    logic tick_reg, tick_next;
    logic oe_n_reg, oe_n_next;
    acbs_spi_out_t spi_reg, spi_next;
    acbs_word_t rom_word, cur_word;
    logic [6:0] rom_addr;
    logic soft_rst;
    assign rom_addr = {straps_reg.cfg_sel, idx_reg}; // [R1] [R3]
    acbs_rom u_rom (
        .mclk(mclk),
        .addr(rom_addr),
        .word(rom_word)
    );
    assign soft_rst = ctrl_reg[CTRL_SOFT_RESET_BIT];
    assign cur_word = (straps_reg.if_sel == IF_EXT && !use_internal_eeprom)
        ? acbs_word_t'(rx_reg) : rom_word;
    always_comb begin
        state_next = state_reg;
        straps_next = straps_reg;
        idx_next = idx_reg;
        bit_next = bit_reg;
        phase_next = phase_reg;
        shift_next = shift_reg;
        rx_next = rx_reg;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        ist_next = ist_reg;
        gss_next = gss_reg;
        pc1_next = pc1_reg;
        eea_next = eea_reg;
        eed_next = eed_reg;
        rdata_next = READ_ZERO;
        done_next = done_reg;
        started_next = started_reg;
        spi_next = spi_reg;
        direct_next = direct_reg;
        tick_next = tick_reg;
        case (state_reg)
            ST_IDLE: begin
                // only reached once per pin reset: soft reset never returns
                if (!started_reg) begin // [R12] [R14]
                    started_next = 1'b1;
                    straps_next = pins_s; // [R15]
                    idx_next = '0;
                    if (pins_s.test && pins_s.cfg_sel == SEL_DIRECT &&
                        pins_s.if_sel == IF_EXT && use_internal_eeprom) begin
                        state_next = ST_DIRECT; // [R6]
                        direct_next = 1'b1;
                    end else if (pins_s.if_sel == IF_EXT &&
                                 !use_internal_eeprom) begin
                        state_next = ST_SPI; // [R4]
                        spi_next.cs_n = 1'b0;
                        shift_next = {SPI_READ_CMD, 1'b0, pins_s.cfg_sel,
                                      4'h0, 8'h00};
                        bit_next = '0;
                        phase_next = 2'h0;
                    end else begin
                        // rom or internal eeprom script [R2] [R5]
                        state_next = ST_FETCH;
                    end
                end
            end
            ST_FETCH: state_next = ST_APPLY;
            ST_SPI: begin
                // sclk at mclk/4: miso passes two sync flops, so a
                // faster sclk would take each bit one period late
                tick_next = ~tick_reg;
                if (tick_reg) begin
                    spi_next.sclk = ~spi_reg.sclk;
                end
                if (tick_reg && spi_reg.sclk) begin
                    rx_next = {rx_reg[14:0], miso_s};
                    bit_next = 4'(bit_reg + 4'h1);
                    if (phase_reg != 2'h3) begin
                        shift_next = {shift_reg[22:0], 1'b0};
                    end
                    // three header bytes once, then 16-bit words
                    if (phase_reg == 2'h3 &&
                        bit_reg == 4'(SPI_BITS + SPI_BITS - 4'h1)) begin
                        state_next = ST_APPLY;
                    end else if (phase_reg != 2'h3 &&
                                 bit_reg == SPI_BITS - 4'h1) begin
                        bit_next = '0;
                        phase_next = 2'(phase_reg + 2'h1);
                    end
                end
                spi_next.mosi = shift_reg[23];
            end
            ST_APPLY: begin
                if (cur_word.addr == ADDR_END ||
                    idx_reg == 4'(SCRIPT_WORDS - 1)) begin
                    state_next = ST_DONE;
                    spi_next = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
                    done_next = 1'b1; // [R13]
                end else begin
                    if (cur_word.addr == ADDR_GPIO0_SS) begin
                        gss_next = cur_word.data; // [R11]
                    end
                    if (cur_word.addr == ADDR_PIN_CTRL1) begin
                        pc1_next = cur_word.data; // [R11]
                    end
                    idx_next = 4'(idx_reg + 4'h1);
                    state_next = (straps_reg.if_sel == IF_EXT &&
                                  !use_internal_eeprom) ? ST_SPI : ST_FETCH;
                end
            end
            ST_DONE: state_next = ST_DONE;
            ST_DIRECT: state_next = ST_DIRECT; // held until pin reset [R8]
            default: state_next = ST_IDLE;
        endcase
        if (direct_reg) begin
            // eeprom window only; ordinary registers unreachable [R7]
            if (reg_write && reg_addr == REG_EE_ADDR) begin
                eea_next = reg_wdata;
            end else if (reg_write && reg_addr == REG_EE_DATA) begin
                eed_next = reg_wdata;
                eea_next = 8'(eea_reg + 8'h01);
                ist_next[INT_EEWR_BIT] = 1'b1;
            end
            if (reg_read && reg_addr == REG_EE_ADDR) begin
                rdata_next = eea_reg;
            end
            if (reg_read && reg_addr == REG_EE_DATA) begin
                rdata_next = eed_reg; // [R7]
            end
        end else begin
            if (reg_write) begin
                case (reg_addr)
                    REG_CTRL: ctrl_next = reg_wdata;
                    REG_INT_MASK: mask_next = reg_wdata;
                    REG_GPIO0_SS: gss_next = reg_wdata;
                    REG_PIN_CTRL1: pc1_next = reg_wdata;
                    default: ;
                endcase
            end
            if (reg_read) begin
                case (reg_addr)
                    REG_CTRL: rdata_next = ctrl_reg;
                    REG_STATUS: rdata_next = {done_reg, 1'b0,
                        straps_reg.if_sel, straps_reg.test,
                        straps_reg.cfg_sel};
                    REG_INT_STATUS: begin
                        rdata_next = ist_reg;
                        ist_next = '0;
                    end
                    REG_INT_MASK: rdata_next = mask_reg;
                    REG_GPIO0_SS: rdata_next = gss_reg;
                    REG_PIN_CTRL1: rdata_next = pc1_reg;
                    default: rdata_next = READ_ZERO;
                endcase
            end
        end
        // set wins over read clear
        if (done_next && !done_reg) begin
            ist_next[INT_DONE_BIT] = 1'b1;
        end
        if (direct_reg && reg_write && reg_addr == REG_EE_DATA) begin
            ist_next[INT_EEWR_BIT] = 1'b1;
        end
        if (soft_rst) begin
            // boot state and done flag survive soft reset [R14]
            ctrl_next = CTRL_RESET;
            mask_next = MASK_RESET;
            gss_next = '0;
            pc1_next = '0;
        end
        gpio_next = (gss_reg == GPIO0_SS_DONE && pc1_reg == PIN_CTRL1_DONE)
            ? done_reg : 1'b0; // [R10]
        irq_next = |(ist_next & mask_next);
        oe_n_next = ~direct_next; // [R9]
    end
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= ST_IDLE;
            straps_reg <= '0;
            idx_reg <= '0;
            bit_reg <= '0;
            phase_reg <= '0;
            shift_reg <= '0;
            rx_reg <= '0;
            ctrl_reg <= CTRL_RESET;
            mask_reg <= MASK_RESET;
            ist_reg <= '0;
            gss_reg <= '0;
            pc1_reg <= '0;
            eea_reg <= '0;
            eed_reg <= '0;
            rdata_reg <= '0;
            done_reg <= 1'b0;
            gpio_reg <= 1'b0;
            irq_reg <= 1'b0;
            direct_reg <= 1'b0;
            started_reg <= 1'b0;
            tick_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            spi_reg <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
        end else begin
            state_reg <= state_next;
            straps_reg <= straps_next;
            idx_reg <= idx_next;
            bit_reg <= bit_next;
            phase_reg <= phase_next;
            shift_reg <= shift_next;
            rx_reg <= rx_next;
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            ist_reg <= ist_next;
            gss_reg <= gss_next;
            pc1_reg <= pc1_next;
            eea_reg <= eea_next;
            eed_reg <= eed_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
            gpio_reg <= gpio_next;
            irq_reg <= irq_next;
            direct_reg <= direct_next;
            started_reg <= started_next;
            tick_reg <= tick_next;
            oe_n_reg <= oe_n_next;
            spi_reg <= spi_next;
        end
    end
    assign reg_rdata = rdata_reg;
    assign spi_out = spi_reg;
    // miso enable low all through direct mode [R9]
    assign spi_miso_oe_n = oe_n_reg;
    assign spi_miso_out = eed_reg[0];
    assign boot_config_done = done_reg;
    assign gpio0_out = gpio_reg;
    assign irq = irq_reg;
    assign direct_write_mode = direct_reg;
endmodule // acbs_boot
`default_nettype wire

// ### acbs_pkg.sv
`default_nettype none
package acbs_pkg;
    localparam int unsigned MCLK_HZ = 100000000;
    localparam int unsigned NUM_CONFIGS = 8;
    localparam int unsigned SCRIPT_WORDS = 16;
    localparam int unsigned ROM_DEPTH = NUM_CONFIGS * SCRIPT_WORDS;
    localparam logic [1:0] IF_ROM0 = 2'h0;
    localparam logic [1:0] IF_ROM1 = 2'h1;
    localparam logic [1:0] IF_ROM2 = 2'h2;
    localparam logic [1:0] IF_EXT = 2'h3;
    localparam logic [2:0] SEL_DIRECT = 3'h0;
    // script word: address byte and data byte
    localparam logic [7:0] ADDR_END = 8'hff;
    localparam logic [7:0] ADDR_GPIO0_SS = 8'h0d;
    localparam logic [7:0] ADDR_PIN_CTRL1 = 8'h0b;
    localparam logic [7:0] GPIO0_SS_DONE = 8'h1f;
    localparam logic [7:0] PIN_CTRL1_DONE = 8'h04;
    localparam logic [7:0] SPI_READ_CMD = 8'h03;
    localparam logic [3:0] SPI_BITS = 4'h8;
    // register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_INT_STATUS = 4'h2;
    localparam logic [3:0] REG_INT_MASK = 4'h3;
    localparam logic [3:0] REG_GPIO0_SS = 4'h4;
    localparam logic [3:0] REG_PIN_CTRL1 = 4'h5;
    localparam logic [3:0] REG_EE_DATA = 4'h6;
    localparam logic [3:0] REG_EE_ADDR = 4'h7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int unsigned CTRL_SOFT_RESET_BIT = 7;
    localparam int unsigned INT_DONE_BIT = 0;
    localparam int unsigned INT_EEWR_BIT = 1;
    localparam logic [7:0] READ_ZERO = 8'h00;
    typedef struct packed {
        logic [1:0] if_sel;
        logic test;
        logic [2:0] cfg_sel;
    } acbs_straps_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } acbs_word_t;
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } acbs_spi_out_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_SPI = 3'b010,
        ST_APPLY = 3'b011,
        ST_DONE = 3'b100,
        ST_DIRECT = 3'b101
    } acbs_state_t;
endpackage
`default_nettype wire

// ### acbs_rom.sv
`default_nettype none
module acbs_rom (
    input wire logic mclk,
    input wire logic [6:0] addr,
    output acbs_pkg::acbs_word_t word
);
    import acbs_pkg::*;
    acbs_word_t mem [0:ROM_DEPTH-1];
    // default scripts: each ties gpio0 to done, then ends
    always_comb begin
        for (int i = 0; i < ROM_DEPTH; i++) begin
            if ((i % SCRIPT_WORDS) == 0) begin
                mem[i] = '{addr: ADDR_GPIO0_SS, data: GPIO0_SS_DONE};
            end else if ((i % SCRIPT_WORDS) == 1) begin
                mem[i] = '{addr: ADDR_PIN_CTRL1, data: PIN_CTRL1_DONE};
            end else begin
                mem[i] = '{addr: ADDR_END, data: 8'(i / SCRIPT_WORDS)};
            end
        end
    end
    always_ff @(posedge mclk) begin
        word <= mem[addr];
    end
endmodule // acbs_rom
`default_nettype wire

// ### acbs_monitor.sv
`default_nettype none
module acbs_monitor
    import acbs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic use_internal_eeprom,
    input wire logic [3:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire acbs_pkg::acbs_spi_out_t spi_out,
    input wire logic spi_miso_oe_n,
    input wire logic boot_config_done,
    input wire logic gpio0_out,
    input wire logic direct_write_mode
);
    logic [11:0] up_reg;
    logic [11:0] up_next;
    // saturating, so the deadline check fires once per reset
    always_comb begin
        up_next = up_reg;
        if (up_reg != 12'hfff) up_next = up_reg + 12'h1;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) up_reg <= 12'h0;
        else up_reg <= up_next;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_miso_driven_direct: assert property (
        direct_write_mode |-> !spi_miso_oe_n)
        else $error("miso released in direct mode");
    a_direct_mode_held: assert property (
        direct_write_mode |=> direct_write_mode)
        else $error("direct mode left without reset");
    a_done_stays_set: assert property (
        boot_config_done |=> boot_config_done)
        else $error("done flag dropped");
    a_gpio_needs_done: assert property (
        gpio0_out |-> boot_config_done)
        else $error("gpio0 high before done");
    a_gpio_follows_done: assert property (
        !use_internal_eeprom && $rose(boot_config_done) |-> ##[0:2] gpio0_out)
        else $error("gpio0 did not follow done");
    a_direct_regs_blocked: assert property (
        direct_write_mode && reg_read && reg_addr < REG_EE_DATA
        |=> reg_rdata == READ_ZERO)
        else $error("register visible in direct mode");
    a_boot_finishes: assert property (
        up_reg == 12'd3000 && !direct_write_mode |-> boot_config_done)
        else $error("boot did not complete");
    a_spi_idle_done: assert property (
        boot_config_done |-> spi_out.cs_n)
        else $error("spi selected after done");
    a_status_shows_done: assert property (
        reg_read && reg_addr == REG_STATUS && !direct_write_mode
        |=> reg_rdata[7] == $past(boot_config_done))
        else $error("status done bit wrong");
endmodule // acbs_monitor
`default_nettype wire

// ### acbs_eeprom_model.sv
`default_nettype none
module acbs_eeprom_model import acbs_pkg::*; (
    input wire acbs_pkg::acbs_spi_out_t spi_in,
    output logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] HDR_BITS = 10'd24;
    logic [9:0] bit_cnt = 10'h0;
    logic [9:0] pos;
    acbs_word_t w;
    initial miso = 1'b0;
    always @(posedge spi_in.sclk or posedge spi_in.cs_n) begin
        if (spi_in.cs_n) bit_cnt <= 10'h0;
        else bit_cnt <= bit_cnt + 10'h1;
    end
    // address ignored: every config holds the done-follow script
    always_comb begin
        pos = bit_cnt - HDR_BITS;
        case (pos[9:4])
            6'h0: w = '{ADDR_GPIO0_SS, GPIO0_SS_DONE};
            6'h1: w = '{ADDR_PIN_CTRL1, PIN_CTRL1_DONE};
            default: w = '{ADDR_END, 8'h00};
        endcase
    end
    // no held value when idle, so a late sample shows up as junk
    always @(negedge spi_in.sclk or posedge spi_in.cs_n) begin
        if (spi_in.cs_n || bit_cnt < HDR_BITS) miso <= ~miso;
        else miso <= w[4'hf - pos[3:0]];
    end
endmodule // acbs_eeprom_model
`default_nettype wire

// ### acbs_boot_bench.sv
`default_nettype none
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("mismatch at %0t got %h want %h", $time, got, exp); \
        end \
    end
module acbs_boot_bench import acbs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk;
    logic rst_n;
    logic [1:0] host_if_select_pins;
    logic test_pin;
    logic [2:0] config_index_select_pins;
    logic use_internal_eeprom;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    acbs_spi_out_t spi_out;
    logic spi_miso_out;
    logic spi_miso_oe_n;
    logic ee_miso;
    logic miso_line;
    logic boot_config_done;
    logic gpio0_out;
    logic irq;
    logic direct_write_mode;
    logic [7:0] d;
    int n_mismatch = 0;
    int samples_checked = 0;
    // shared miso wire: device wins while its enable is low
    assign miso_line = spi_miso_oe_n ? ee_miso : spi_miso_out;
    acbs_boot dut (.mclk(mclk), .rst_n(rst_n),
        .host_if_select_pins(host_if_select_pins), .test_pin(test_pin),
        .config_index_select_pins(config_index_select_pins),
        .use_internal_eeprom(use_internal_eeprom), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .spi_out(spi_out),
        .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n),
        .spi_miso_in(miso_line), .boot_config_done(boot_config_done),
        .gpio0_out(gpio0_out), .irq(irq),
        .direct_write_mode(direct_write_mode));
    acbs_eeprom_model eeprom (.spi_in(spi_out), .miso(ee_miso));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic boot(input logic [1:0] i, input logic t,
                        input logic [2:0] s, input logic ie);
        @(posedge mclk);
        rst_n <= 1'b0;
        host_if_select_pins <= i;
        test_pin <= t;
        config_index_select_pins <= s;
        use_internal_eeprom <= ie;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        // scramble pins: the latched copy must not follow
        host_if_select_pins <= ~i;
        test_pin <= ~t;
        config_index_select_pins <= ~s;
        #1;
    endtask
    task automatic check_boot(input logic [1:0] i, input logic t,
                              input logic [2:0] s);
        for (int n = 0; n < 4000 && boot_config_done !== 1'b1; n++)
            @(posedge mclk);
        rd(REG_STATUS, d);
        `CHK(d, {1'b1, 1'b0, i, t, s})
        `CHK(direct_write_mode, 1'b0)
    endtask
    task automatic t_rom;
        for (int k = 0; k < NUM_CONFIGS; k++) begin
            boot(2'(k % 3), 1'b0, 3'(k), 1'b0);
            check_boot(2'(k % 3), 1'b0, 3'(k));
            `CHK(gpio0_out, 1'b1)
        end
    endtask
    task automatic t_ext;
        boot(IF_EXT, 1'b0, 3'h5, 1'b0);
        check_boot(IF_EXT, 1'b0, 3'h5);
        `CHK(gpio0_out, 1'b1)
        boot(IF_EXT, 1'b0, 3'h2, 1'b1);
        check_boot(IF_EXT, 1'b0, 3'h2);
        boot(IF_EXT, 1'b1, 3'h3, 1'b1);
        check_boot(IF_EXT, 1'b1, 3'h3);
        boot(IF_ROM2, 1'b1, SEL_DIRECT, 1'b1);
        check_boot(IF_ROM2, 1'b1, SEL_DIRECT);
    endtask
    task automatic t_direct;
        boot(IF_EXT, 1'b1, SEL_DIRECT, 1'b1);
        `CHK(direct_write_mode, 1'b1)
        `CHK(spi_miso_oe_n, 1'b0)
        rd(REG_STATUS, d);
        `CHK(d, READ_ZERO)
        wr(REG_EE_ADDR, 8'h10);
        wr(REG_EE_DATA, 8'ha5);
        rd(REG_EE_ADDR, d);
        `CHK(d, 8'h11)
        wr(REG_EE_ADDR, 8'h10);
        rd(REG_EE_DATA, d);
        `CHK(d, 8'ha5)
        boot(IF_ROM0, 1'b0, 3'h1, 1'b1);
        `CHK(direct_write_mode, 1'b0)
        `CHK(spi_miso_oe_n, 1'b1)
    endtask
    task automatic t_soft;
        boot(IF_EXT, 1'b0, 3'h6, 1'b0);
        check_boot(IF_EXT, 1'b0, 3'h6);
        rd(REG_CTRL, d);
        `CHK(d, CTRL_RESET)
        wr(REG_CTRL, 8'h80);
        // a relaunch would select the eeprom again
        repeat (60) begin
            @(posedge mclk);
            #1;
            `CHK({spi_out.cs_n, boot_config_done}, 2'b11)
        end
        check_boot(IF_EXT, 1'b0, 3'h6);
    endtask
    task automatic t_irq;
        logic a;
        boot(IF_ROM0, 1'b0, 3'h3, 1'b0);
        check_boot(IF_ROM0, 1'b0, 3'h3);
        rd(REG_INT_MASK, d);
        `CHK(d, MASK_RESET)
        wr(REG_INT_MASK, 8'h00);
        repeat (2) @(posedge mclk);
        #1 a = irq;
        wr(REG_INT_MASK, 8'hff);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(a, 1'b0)
        `CHK(irq, 1'b1)
        rd(REG_INT_STATUS, d);
        `CHK(d[INT_DONE_BIT], 1'b1)
        rd(REG_INT_STATUS, d);
        `CHK(d, 8'h00)
        wr(REG_INT_MASK, 8'h00);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(irq, 1'b0)
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        host_if_select_pins = 2'h0;
        test_pin = 1'b0;
        config_index_select_pins = 3'h0;
        use_internal_eeprom = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        t_rom();
        t_ext();
        t_direct();
        t_soft();
        t_irq();
        summarize();
    end
endmodule // acbs_boot_bench
bind acbs_boot acbs_monitor u_monitor (.mclk(mclk), .rst_n(rst_n),
    .use_internal_eeprom(use_internal_eeprom), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .spi_out(spi_out),
    .spi_miso_oe_n(spi_miso_oe_n), .boot_config_done(boot_config_done),
    .gpio0_out(gpio0_out), .direct_write_mode(direct_write_mode));
`default_nettype wire
